// ### rtl/rfsq_cfg.svh
/*
 * rfsq_cfg.svh: offsets, field positions, reset values and timing counts
 * for the transponder read/write sequencer.
 * Assumes: included by bare name; counts are in field clocks.
 */
`ifndef RFSQ_CFG_SVH
`define RFSQ_CFG_SVH

// ****************************************************************
// apb register offsets (byte addresses)
// ****************************************************************
`define RFSQ_OFS_MEM0     8'h00
`define RFSQ_OFS_TRACE1   8'h20
`define RFSQ_OFS_TRACE2   8'h24
`define RFSQ_OFS_STATUS   8'h28
`define RFSQ_OFS_CFG      8'h2C
`define RFSQ_MEM_WORDS    10

// ****************************************************************
// configuration word fields (memory bit n sits at word bit 32-n)
// ****************************************************************
`define RFSQ_LIMIT_MSB    2
`define RFSQ_LIMIT_LSB    0
`define RFSQ_ST_BIT       3
`define RFSQ_PWD_BIT      4
`define RFSQ_POR_BIT      8
`define RFSQ_MOD_MSB      15
`define RFSQ_MOD_LSB      11
`define RFSQ_XMODE_BIT    17
`define RFSQ_RATE_MSB     20
`define RFSQ_RATE_LSB     18
`define RFSQ_MOD_MANCH    5'h08
`define RFSQ_CFG_RESET    32'h00000000

// ****************************************************************
// timing counts in field clocks
// ****************************************************************
`define RFSQ_CFG_FC       14'd192
`define RFSQ_DELAY_FC     14'd8190
`define RFSQ_RX_TMO_FC    14'd64
`define RFSQ_ZERO_MIN     14'd16
`define RFSQ_ZERO_MAX     14'd31
`define RFSQ_ONE_MIN      14'd48
`define RFSQ_ONE_MAX      14'd63

// ****************************************************************
// received command lengths in bits
// ****************************************************************
`define RFSQ_LEN_OPC      7'd2
`define RFSQ_LEN_DA       7'd6
`define RFSQ_LEN_AOR      7'd34
`define RFSQ_LEN_LONG     7'd38
`define RFSQ_LEN_PWWR     7'd70

`endif

// ### rtl/rfsq_pkg.sv
/*
 * rfsq_pkg: state types of the transponder read/write sequencer.
 * Assumes: compiled before rfsq_top.
 */
package rfsq_pkg;

	// main operating state
	typedef enum logic [1:0] {
		S_CFG,
		S_DELAY,
		S_READ,
		S_RX
	} rfsq_state_t;

	// position inside the transmit stream
	typedef enum logic [1:0] {
		T_ZERO,
		T_TERM,
		T_DATA
	} rfsq_tx_t;

	// whole state of the top module, except the memory
	typedef struct packed {
		logic        fc_m;
		logic        fc_s;
		logic        fc_d;
		logic        gp_m;
		logic        gp_s;
		logic        gp_d;
		rfsq_state_t st;
		rfsq_tx_t    tph;
		logic [13:0] cnt;
		logic [6:0]  per;
		logic [4:0]  bitn;
		logic [1:0]  termn;
		logic [2:0]  blk;
		logic        blkrd;
		logic [2:0]  sel_blk;
		logic        page;
		logic [31:0] cfg;
		logic [69:0] sh;
		logic [6:0]  nbits;
		logic        err;
		logic        mod;
		logic        txb;
		logic        rxd;
		logic [31:0] rdata;
		logic        ready;
		logic        slverr;
	} rfsq_regs_t;

endpackage

// ### rtl/rfsq_top.sv
/*
 * rfsq_top: control logic of a contactless transponder. Loads its
 * configuration, applies the start-up delay, streams memory blocks as
 * an nrz bit stream with damping level, and decodes reader commands
 * carried as gaps in the field. Memory contents are loaded over apb.
 * Assumes: i_fc is the recovered field clock and i_gap is high while
 * the field is off, both asynchronous to i_clk and far slower than it.
 */
`timescale 1ns/100ps
`include "rfsq_cfg.svh"

//Contract
//- load config from block 0 over 192 clocks
//- damping option: damp while loading configuration
//- startup hold bit adds 8190 clocks damping
//- gap during initialization restarts whole sequence
//- after initialization enter regular-read automatically
//- stream block 1 through limit, then wrap
//- limit 0..7; 1 repeats block1; 0 sends config
//- send one zero bit on entering read
//- opcode, zero, address selects repeated block read
//- password required; mismatch returns to regular read
//- page 1: block0 gives config, 3..7 zeros
//- terminator four ones, periods 2,4 modulation off; code keeps it on for manchester
//- terminator only with bit 29 and legacy mode
//- regular read: terminator at each pass start
//- block read or limit 0/1: terminator per block
//- gap spacing 24 means zero, 54 one
//- over 64 clocks idle ends write, check count
//- any failure abandons command, regular read
//- receive damping on from start gap to end
//- start gap accepted once configuration loaded; in startup hold delay a gap restarts
//- lone gap keeps previously selected page
//- opcode 1p page, 00 reset, 01 test; code rejects 01
//- spacing 16..31 zero, 48..63 one
module rfsq_top #(
	parameter int  DAMP_OPT = 1                // 1: damping option fitted
) (
	input  wire logic        i_clk,            // system clock, 25 MHz
	input  wire logic        i_rstn,           // power-on reset, active low
	input  wire logic        i_fc,             // recovered field clock
	input  wire logic        i_gap,            // high while field is off
	input  wire logic        i_psel,           // apb select
	input  wire logic        i_penable,        // apb enable
	input  wire logic        i_pwrite,         // apb write
	input  wire logic [7:0]  i_paddr,          // apb byte address
	input  wire logic [31:0] i_pwdata,         // apb write data
	output logic      [31:0] o_prdata,         // apb read data
	output logic             o_pready,         // apb ready
	output logic             o_pslverr,        // apb error, unmapped or write to status/config
	output logic             o_mod,            // load damping on
	output logic             o_tx_bit,         // underlying transmit bit
	output logic             o_rx_damp         // receive damping on
);
	import rfsq_pkg::*;

	// ****************************************************************
	// state and memory
	// ****************************************************************
	rfsq_regs_t  r;
	rfsq_regs_t  next_r;
	logic [31:0] mem [`RFSQ_MEM_WORDS];

	logic        fc_rise;
	logic        gap_rise;
	logic [6:0]  rate_m1;
	logic [2:0]  lim;
	logic        st_on;
	logic        manch;
	logic [31:0] cur_word;
	logic [2:0]  first_blk;
	logic [2:0]  last_blk;
	logic        bit_val;
	logic        bit_ok;
	logic [1:0]  op;
	logic        pw_ok;
	logic        cmd_ok;
	logic        cmd_blk;
	logic [2:0]  cmd_addr;
	logic        apb_setup;
	logic [3:0]  widx;

	// ****************************************************************
	// decoded helpers
	// ****************************************************************

	// edges of synchronised field clock and gap
	assign fc_rise  = r.fc_s & ~r.fc_d;
	assign gap_rise = r.gp_s & ~r.gp_d;
	assign lim      = r.cfg[`RFSQ_LIMIT_MSB:`RFSQ_LIMIT_LSB];
	assign st_on    = r.cfg[`RFSQ_ST_BIT] & ~r.cfg[`RFSQ_XMODE_BIT];
	assign manch    = (r.cfg[`RFSQ_MOD_MSB:`RFSQ_MOD_LSB] == `RFSQ_MOD_MANCH);
	assign apb_setup = i_psel & ~i_penable;
	assign widx     = i_paddr[5:2];

	// bit period in field clocks, minus one
	always_comb begin
		unique case (r.cfg[`RFSQ_RATE_MSB:`RFSQ_RATE_LSB])
			3'h0: rate_m1 = 7'd7;
			3'h1: rate_m1 = 7'd15;
			3'h2: rate_m1 = 7'd31;
			3'h3: rate_m1 = 7'd39;
			3'h4: rate_m1 = 7'd49;
			3'h5: rate_m1 = 7'd63;
			3'h6: rate_m1 = 7'd99;
			3'h7: rate_m1 = 7'd127;
		endcase
	end

	// block range of one pass
	always_comb begin
		if (r.blkrd) begin
			first_blk = r.sel_blk;
			last_blk  = r.sel_blk;
		end else begin
			first_blk = (lim == 3'h0) ? 3'h0 : 3'h1;
			last_blk  = lim;
		end
	end

	// word of the block being sent
	always_comb begin
		cur_word = 32'h00000000;
		if (!r.page || r.blk == 3'h0) begin
			cur_word = mem[r.blk];
		end else if (r.blk == 3'h1 || r.blk == 3'h2) begin
			cur_word = (r.blk == 3'h1) ? mem[8] : mem[9];
		end
	end

	// classify a gap spacing
	always_comb begin
		bit_val = 1'b0;
		bit_ok  = 1'b0;
		if (r.cnt >= `RFSQ_ZERO_MIN && r.cnt <= `RFSQ_ZERO_MAX) begin
			bit_ok = 1'b1;
		end else if (r.cnt >= `RFSQ_ONE_MIN && r.cnt <= `RFSQ_ONE_MAX) begin
			bit_ok  = 1'b1;
			bit_val = 1'b1;
		end
	end

	// decode a finished command
	always_comb begin
		cmd_ok   = 1'b0;
		cmd_blk  = 1'b0;
		cmd_addr = r.sh[2:0];
		op       = 2'b00;
		pw_ok    = 1'b0;
		unique case (r.nbits)
			`RFSQ_LEN_OPC: begin
				op     = r.sh[1:0];
				cmd_ok = (op != 2'b01);
			end
			`RFSQ_LEN_DA: begin
				op      = r.sh[5:4];
				cmd_ok  = op[1] & ~r.sh[3] & ~r.cfg[`RFSQ_PWD_BIT];
				cmd_blk = 1'b1;
			end
			`RFSQ_LEN_AOR: begin
				op     = r.sh[33:32];
				pw_ok  = (r.sh[31:0] == mem[7]);
				cmd_ok = op[1] & r.cfg[`RFSQ_PWD_BIT] & pw_ok;
			end
			`RFSQ_LEN_LONG: begin
				op      = r.sh[37:36];
				pw_ok   = (r.sh[35:4] == mem[7]);
				// password direct access, or plain write
				cmd_ok  = op[1] & (r.cfg[`RFSQ_PWD_BIT] ?
					(pw_ok & ~r.sh[3]) : 1'b1);
				cmd_blk = 1'b1;
			end
			`RFSQ_LEN_PWWR: begin
				op      = r.sh[69:68];
				pw_ok   = (r.sh[67:36] == mem[7]);
				cmd_ok  = op[1] & r.cfg[`RFSQ_PWD_BIT] & pw_ok;
				cmd_blk = 1'b1;
			end
			default: begin
				cmd_ok = 1'b0;
			end
		endcase
		cmd_ok = cmd_ok & ~r.err;
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		next_r      = r;
		next_r.fc_m = i_fc;
		next_r.fc_s = r.fc_m;
		next_r.fc_d = r.fc_s;
		next_r.gp_m = i_gap;
		next_r.gp_s = r.gp_m;
		next_r.gp_d = r.gp_s;

		unique case (r.st)
			S_CFG: begin
				if (fc_rise) begin
					next_r.cnt = r.cnt + 14'd1;
				end
				if (fc_rise && r.cnt == `RFSQ_CFG_FC - 14'd1) begin
					next_r.cfg = mem[0];
					next_r.cnt = 14'd0;
					if (mem[0][`RFSQ_POR_BIT]) begin
						next_r.st = S_DELAY;
					end else begin
						next_r.st    = S_READ;
						next_r.blkrd = 1'b0;
						next_r.tph   = T_ZERO;
						next_r.per   = 7'd0;
						next_r.bitn  = 5'd31;
						next_r.blk   = (mem[0][`RFSQ_LIMIT_MSB:`RFSQ_LIMIT_LSB] == 3'h0)
							? 3'h0 : 3'h1;
					end
				end
			end
			S_DELAY: begin
				if (fc_rise) begin
					next_r.cnt = r.cnt + 14'd1;
				end
				if (fc_rise && r.cnt == `RFSQ_DELAY_FC - 14'd1) begin
					next_r.st    = S_READ;
					next_r.blkrd = 1'b0;
					next_r.tph   = T_ZERO;
					next_r.per   = 7'd0;
					next_r.bitn  = 5'd31;
					next_r.blk   = (lim == 3'h0) ? 3'h0 : 3'h1;
				end
			end
			S_READ: begin
				if (gap_rise) begin
					next_r.st    = S_RX;
					next_r.cnt   = 14'd0;
					next_r.nbits = 7'd0;
					next_r.err   = 1'b0;
					next_r.sh    = 70'h0;
				end else if (fc_rise) begin
					if (r.per == rate_m1) begin
						next_r.per = 7'd0;
						unique case (r.tph)
							T_ZERO: begin
								next_r.tph   = st_on ? T_TERM : T_DATA;
								next_r.termn = 2'd0;
								next_r.bitn  = 5'd31;
							end
							T_TERM: begin
								next_r.termn = r.termn + 2'd1;
								if (r.termn == 2'd3) begin
									next_r.tph = T_DATA;
								end
							end
							T_DATA: begin
								next_r.bitn = r.bitn - 5'd1;
								if (r.bitn == 5'd0) begin
									if (r.blk == last_blk) begin
										next_r.blk   = first_blk;
										next_r.termn = 2'd0;
										// new pass: terminator first
										next_r.tph   = st_on ? T_TERM : T_DATA;
									end else begin
										next_r.blk = r.blk + 3'h1;
									end
								end
							end
							default: begin
								next_r.tph = T_ZERO;
							end
						endcase
					end else begin
						next_r.per = r.per + 7'd1;
					end
				end
			end
			S_RX: begin
				if (fc_rise && r.cnt != 14'h3FFF) begin
					next_r.cnt = r.cnt + 14'd1;
				end
				if (gap_rise) begin
					next_r.cnt = 14'd0;
					next_r.sh  = {r.sh[68:0], bit_val};
					if (!bit_ok || r.nbits == 7'h7F) begin
						next_r.err = 1'b1;
					end else begin
						next_r.nbits = r.nbits + 7'd1;
					end
				end else if (fc_rise && r.cnt >= `RFSQ_RX_TMO_FC) begin
					// leave write mode, act on the command
					next_r.st   = S_READ;
					next_r.tph  = T_ZERO;
					next_r.per  = 7'd0;
					next_r.bitn = 5'd31;
					next_r.cnt  = 14'd0;
					if (cmd_ok && r.nbits == `RFSQ_LEN_OPC && op == 2'b00) begin
						next_r.st = S_CFG;
					end
					if (cmd_ok && op[1]) begin
						next_r.page    = op[0];
						next_r.blkrd   = cmd_blk;
						next_r.sel_blk = cmd_addr;
					end else begin
						next_r.blkrd = 1'b0;
					end
					if (cmd_ok && cmd_blk) begin
						next_r.blk = cmd_addr;
					end else begin
						next_r.blk = (lim == 3'h0) ? 3'h0 : 3'h1;
					end
				end
			end
		endcase

		// a gap during initialization starts it again
		if ((r.st == S_CFG || r.st == S_DELAY) && gap_rise) begin
			next_r.st  = S_CFG;
			next_r.cnt = 14'd0;
		end

		// damping and transmit bit outputs
		next_r.rxd = (r.st == S_RX);
		next_r.txb = 1'b0;
		unique case (r.st)
			S_CFG:   next_r.mod = (DAMP_OPT != 0);
			S_DELAY: next_r.mod = 1'b1;
			S_RX:    next_r.mod = 1'b1;
			S_READ: begin
				unique case (r.tph)
					T_ZERO: next_r.mod = 1'b0;
					T_TERM: begin
						next_r.txb = 1'b1;
						next_r.mod = r.termn[0] ? manch : 1'b1;
					end
					default: begin
						next_r.txb = cur_word[r.bitn];
						next_r.mod = cur_word[r.bitn];
					end
				endcase
			end
		endcase

		// apb slave: answer in the cycle after setup
		next_r.ready  = apb_setup;
		next_r.slverr = 1'b0;
		next_r.rdata  = 32'h00000000;
		if (apb_setup) begin
			if (i_paddr[1:0] != 2'b00 || i_paddr[7:2] > 6'h0B) begin
				next_r.slverr = 1'b1;
			end else if (i_paddr == `RFSQ_OFS_STATUS) begin
				next_r.rdata = {16'h0000, r.nbits, r.blk, r.page, r.blkrd,
					r.st, r.tph};
			end else if (i_paddr == `RFSQ_OFS_CFG) begin
				next_r.rdata = r.cfg;
			end else begin
				next_r.rdata = mem[widx];
			end
			if (i_pwrite && i_paddr >= `RFSQ_OFS_STATUS) begin
				next_r.slverr = 1'b1;
			end
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************

	// state register
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r       <= '0;
			r.st    <= S_CFG;
			r.tph   <= T_ZERO;
			r.cfg   <= `RFSQ_CFG_RESET;
			r.bitn  <= 5'd31;
		end else begin
			r <= next_r;
		end
	end

	// memory contents, written at the access phase
	always_ff @(posedge i_clk) begin
		if (i_psel && i_penable && r.ready && !r.slverr && i_pwrite) begin
			mem[widx] <= i_pwdata;
		end
	end

	// outputs straight from flip-flops
	assign o_prdata  = r.rdata;
	assign o_pready  = r.ready;
	assign o_pslverr = r.slverr;
	assign o_mod     = r.mod;
	assign o_tx_bit  = r.txb;
	assign o_rx_damp = r.rxd;

endmodule

// ### dv/rfsq_reader.sv
/* rfsq_reader: reader model, free field clock and field gaps.
   Assumes: the bench calls send() by hierarchical name. */
`timescale 1ns/100ps
module rfsq_reader (
	output logic o_fc,  // field clock
	output logic o_gap  // high while field is off
);
	// ****************
	// field and gaps
	// ****************
	// carrier runs free, phase unrelated to the bench clock
	initial begin
		o_fc = 1'b0;
		o_gap = 1'b0;
		#7;
		forever #160 o_fc = ~o_fc;
	end
	// one gap of 8 field clocks
	task automatic pulse();
		o_gap = 1'b1;
		repeat (8) @(posedge o_fc);
		o_gap = 1'b0;
	endtask
	// start gap, then one gap per bit, first bit first
	task automatic send(input logic [69:0] b, input int n);
		pulse();
		for (int i = n - 1; i >= 0; i--) begin
			repeat (b[i] ? 46 : 16) @(posedge o_fc);
			pulse();
		end
	endtask
endmodule

// ### dv/rfsq_top_asserts.sv
/* rfsq_top_asserts: port checker for rfsq_top.
   Assumes: i_fc far slower than i_clk; reset async, active low. */
`timescale 1ns/100ps
module rfsq_top_asserts #(
	parameter int DAMP_OPT = 1 // damping option fitted
) (
	input wire logic        i_clk,     // clock
	input wire logic        i_rstn,    // reset, active low
	input wire logic        i_fc,      // field clock
	input wire logic        i_gap,     // field off
	input wire logic        i_psel,    // apb select
	input wire logic        i_penable, // apb enable
	input wire logic        i_pwrite,  // apb write
	input wire logic [7:0]  i_paddr,   // apb address
	input wire logic [31:0] i_pwdata,  // apb write data
	input wire logic [31:0] o_prdata,  // apb read data
	input wire logic        o_pready,  // apb ready
	input wire logic        o_pslverr, // apb error
	input wire logic        o_mod,     // load damping
	input wire logic        o_tx_bit,  // sent bit
	input wire logic        o_rx_damp  // receive damping
);
	// ****************
	// field clock counters
	// ****************
	logic [2:0]  fsy;  // field clock sync
	logic [2:0]  gsy;  // gap sync
	logic [13:0] n_fc; // field clocks since last gap
	logic [7:0]  n_in; // field clocks into initialization
	logic        fr;   // field clock rise
	logic        gr;   // gap rise
	assign fr = fsy[1] & ~fsy[2];
	assign gr = gsy[1] & ~gsy[2];
	// a gap restarts the init count only while still initializing
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			fsy <= 3'h0;
			gsy <= 3'h0;
			n_fc <= 14'h0;
			n_in <= 8'h0;
		end else begin
			fsy <= {fsy[1:0], i_fc};
			gsy <= {gsy[1:0], i_gap};
			n_fc <= gr ? 14'h0 : n_fc + 14'(fr && n_fc != 14'h3FFF);
			n_in <= (gr && n_in < 8'hBE) ? 8'h0 : n_in + 8'(fr && n_in < 8'hC8);
		end
	end
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	property p_por_damp;
		(DAMP_OPT == 1 && $rose(i_rstn)) |-> ##[1:2] o_mod;
	endproperty
	a_por_damp: assert property (p_por_damp) else $error("no damping after reset");
	property p_init_damp;
		(DAMP_OPT == 1 && n_in != 8'h0 && n_in < 8'hBE) |-> o_mod;
	endproperty
	a_init_damp: assert property (p_init_damp) else $error("damping off in init");
	property p_rx_mod;
		o_rx_damp |-> o_mod;
	endproperty
	a_rx_mod: assert property (p_rx_mod) else $error("rx damping without load");
	property p_rx_hold;
		o_rx_damp |-> n_fc < 14'h44;
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("write mode kept too long");
	property p_rx_end;
		$fell(o_rx_damp) |-> n_fc > 14'h3F;
	endproperty
	a_rx_end: assert property (p_rx_end) else $error("write mode left early");
	property p_lead;
		$fell(o_rx_damp) |-> (!o_tx_bit) [*8];
	endproperty
	a_lead: assert property (p_lead) else $error("no leading zero");
	property p_bit_hold;
		$changed(o_tx_bit) |=> (o_rx_damp || $stable(o_tx_bit)) [*8];
	endproperty
	a_bit_hold: assert property (p_bit_hold) else $error("bit period too short");
	property p_ready;
		(i_psel && !i_penable) |=> o_pready;
	endproperty
	a_ready: assert property (p_ready) else $error("apb ready missing");
	property p_err;
		o_pslverr |-> o_pready && i_penable;
	endproperty
	a_err: assert property (p_err) else $error("apb error outside access");
	c_rx: cover property ($rose(o_rx_damp));
	c_err: cover property (o_pslverr);
	c_one: cover property ($rose(o_tx_bit));
endmodule

bind rfsq_top rfsq_top_asserts #(.DAMP_OPT(DAMP_OPT)) u_chk (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_fc(i_fc), .i_gap(i_gap), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_mod(o_mod),
	.o_tx_bit(o_tx_bit), .o_rx_damp(o_rx_damp)
);

// ### dv/rfsq_top_bench.sv
/* rfsq_top_bench: self-checking bench for rfsq_top.
   Assumes: rfsq_reader drives the field; memory is loaded over apb. */
`timescale 1ns/100ps
module rfsq_top_bench;
	// ****************
	// signals and instances
	// ****************
	logic        i_clk, i_rstn, i_psel, i_penable, i_pwrite, fc, gap, er;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic        o_pready, o_pslverr, o_mod, o_tx_bit, o_rx_damp;
	int          fails, n_checks;
	logic [4:0]  rows [6]; // page, block, first data bit
	localparam logic [31:0] CFG_A = 32'h8000000A; // limit 2, terminator on
	localparam logic [31:0] CFG_P = 32'h80000012; // limit 2, password on
	always #20 i_clk = ~i_clk;
	rfsq_reader rdr (.o_fc(fc), .o_gap(gap));
	rfsq_top #(.DAMP_OPT(1)) dut (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_fc(fc), .i_gap(gap), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_mod(o_mod),
		.o_tx_bit(o_tx_bit), .o_rx_damp(o_rx_damp)
	);
	// ****************
	// tasks
	// ****************
	task automatic test_done();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		chk_w({31'h0, g}, {31'h0, e});
	endtask
	// one apb transfer, held until ready is sampled high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
		end while (o_pready !== 1'b1 && k < 50);
		if (k == 50) begin
			fails++;
			$display("[FAIL] %0t no pready", $time);
		end
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	// poll status until the masked fields match
	task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
		int k;
		k = 0;
		n_checks++;
		do begin
			apb(1'b0, 8'h28, 32'h0);
			k++;
		end while ((rd & m) !== v && k < 5000);
		if (k == 5000) begin
			fails++;
			$display("[FAIL] %0t status %h", $time, rd);
		end
	endtask
	// reset, then load both pages before configuration is taken
	task automatic boot(input logic [31:0] cfg);
		logic [31:0] w;
		i_rstn <= 1'b0;
		repeat (5) @(posedge i_clk);
		chk_b(o_mod, 1'b0);
		i_rstn <= 1'b1;
		apb(1'b1, 8'h00, cfg);
		for (int i = 1; i < 10; i++) begin
			w = i == 8 ? 32'hF0000001 : i == 9 ? 32'h2 : 32'h80000000 + 32'(i);
			apb(1'b1, 8'(4 * i), w);
		end
	endtask
	// wait out write mode, then expect the leading zero
	task automatic end_cmd();
		int k;
		k = 0;
		chk_b(o_rx_damp, 1'b1);
		chk_b(o_mod, 1'b1);
		while (o_rx_damp !== 1'b0 && k < 2000) begin
			@(posedge i_clk);
			k++;
		end
		if (k == 2000) begin
			fails++;
			$display("[FAIL] %0t write mode stuck", $time);
		end
		apb(1'b0, 8'h28, 32'h0);
		chk_w(32'(rd[1:0]), 32'h0);
		chk_b(o_tx_bit, 1'b0);
	endtask
	// ****************
	// tests
	// ****************
	initial begin
		{i_clk, i_rstn, i_psel, i_penable, i_pwrite} = 5'h0;
		i_paddr = 8'h0;
		i_pwdata = 32'h0;
		fails = 0;
		n_checks = 0;
		rows = '{5'h07, 5'h0F, 5'h11, 5'h13, 5'h14, 5'h18};
		boot(CFG_A);
		repeat (800) @(posedge i_clk);
		rdr.send(70'h0, 0);
		repeat (1200) @(posedge i_clk);
		apb(1'b0, 8'h28, 32'h0);
		chk_w(32'(rd[3:2]), 32'h0);
		wait_st(32'hC, 32'h8);
		apb(1'b0, 8'h2C, 32'h0);
		chk_w(rd, CFG_A);
		apb(1'b0, 8'h0C, 32'h0);
		chk_w(rd, 32'h80000003);
		apb(1'b1, 8'h30, 32'h0);
		chk_b(er, 1'b1);
		apb(1'b1, 8'h2C, 32'h0);
		chk_b(er, 1'b1);
		$display("init and registers done");
		foreach (rows[i]) begin
			rdr.send(70'({1'b1, rows[i][4], 1'b0, rows[i][3:1]}), 6);
			end_cmd();
			chk_w(32'(rd[8:4]), 32'({rows[i][3:1], rows[i][4], 1'b1}));
			wait_st(32'h3, 32'h1);
			chk_b(o_tx_bit, 1'b1);
			chk_b(o_mod, 1'b1);
			repeat (64) @(posedge i_clk);
			chk_b(o_mod, 1'b0);
			wait_st(32'h3, 32'h2);
			chk_b(o_tx_bit, rows[i][0]);
		end
		$display("direct access rows done");
		rdr.send(70'h0, 0);
		end_cmd();
		chk_w(32'(rd[5:4]), 32'h2);
		rdr.send(70'h2, 2);
		end_cmd();
		chk_w(32'(rd[5:4]), 32'h0);
		wait_st(32'h1C3, 32'h42);
		wait_st(32'h1C3, 32'h82);
		wait_st(32'h3, 32'h1);
		wait_st(32'h1C3, 32'h42);
		rdr.send(70'({2'b10, 1'b0, 32'h0, 3'h5}), 38);
		end_cmd();
		chk_w(32'(rd[8:4]), 32'h15);
		rdr.send(70'h0, 2);
		end_cmd();
		chk_w(32'(rd[3:2]), 32'h0);
		wait_st(32'hC, 32'h8);
		$display("regular read done");
		boot(CFG_P);
		wait_st(32'hC, 32'h8);
		rdr.send(70'({2'b10, 32'h12345678, 4'h3}), 38);
		end_cmd();
		chk_w(32'(rd[4]), 32'h0);
		rdr.send(70'({2'b10, 32'h80000007, 4'h3}), 38);
		end_cmd();
		chk_w(32'(rd[8:4]), 32'hD);
		$display("password done");
		test_done();
	end
	// cut a hang short
	initial begin
		#4000000;
		fails++;
		$display("[FAIL] %0t watchdog", $time);
		test_done();
	end
endmodule
